/* File: hw/rtcf_flags_ctrl.sv */
// flag and control byte of the timekeeper with its sram-style pin access
`timescale 1ns/1ps
module rtcf_flags_ctrl
  import rtcf_pkg::*;
#(
  parameter int OSC_CYCLES = rtcf_pkg::OSC_CHECK_CYCLES,
  parameter int CAL_CYCLES = rtcf_pkg::CAL_HALF_CYCLES
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [rtcf_pkg::ADDR_W-1:0] addr_i,
  input wire logic [rtcf_pkg::DATA_W-1:0] dq_i,
  output logic [rtcf_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic power_fail_threshold_i,
  input wire logic osc_running_i,
  input wire logic osc_fail_kept_i,
  input wire logic alarm_match_i,
  input wire logic watchdog_zero_i,
  input wire logic int_request_i,
  output logic int_o,
  output logic int_oe_o,
  output logic time_hold_o,
  output logic time_load_o,
  output logic snapshot_o,
  output logic clk_reg_wr_o,
  output logic [rtcf_pkg::ADDR_W-1:0] clk_reg_addr_o,
  output logic [rtcf_pkg::DATA_W-1:0] clk_reg_data_o,
  output logic osc_fail_flag_o
);
  import rtcf_pkg::*;

  // a zero count would leave both dividers stuck, so refuse it at elaboration
  if (OSC_CYCLES < 1 || CAL_CYCLES < 1) begin : g_bad_count
    $error("counts must be at least one");
  end

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int SW = ADDR_W + DATA_W + 5;
  logic [SW-1:0] pins_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic ce_n_s;
  logic we_n_s;
  logic oe_n_s;
  logic pfail_s;
  logic osc_run_s;

  rtcf_sync #(
    .W(SW),
    .RST_VAL({{(ADDR_W + DATA_W){1'b0}}, 5'h1c})
  ) u_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i({addr_i, dq_i, ce_n_i, we_n_i, oe_n_i, power_fail_threshold_i, osc_running_i}),
    .sync_o(pins_s)
  );

  assign {addr_s, data_s, ce_n_s, we_n_s, oe_n_s, pfail_s, osc_run_s} = pins_s;

  //////////////////////////////////////////////////////////////////////
  // bus cycle detection
  // address and data are taken from synchronised pins; host must hold
  // them stable for the whole strobe, as an async sram cycle does
  logic wr_act;
  logic rd_act;
  logic wr_act_q;
  logic rd_act_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [DATA_W-1:0] wr_data_q;
  logic [ADDR_W-1:0] wr_addr_d;
  logic [DATA_W-1:0] wr_data_d;
  logic rd_flags_q;
  logic rd_flags_d;
  logic wr_end;
  logic rd_start;
  logic rd_end;

  always_comb begin
    wr_act = !ce_n_s && !we_n_s;
    rd_act = !ce_n_s && we_n_s && !oe_n_s;
    wr_end = wr_act_q && !wr_act;
    rd_start = rd_act && !rd_act_q;
    rd_end = rd_act_q && !rd_act;
    wr_addr_d = wr_act ? addr_s : wr_addr_q;
    wr_data_d = wr_act ? data_s : wr_data_q;
    rd_flags_d = rd_start ? (addr_s == FLAGS_ADDR) : (rd_end ? 1'b0 : rd_flags_q);
  end

  //////////////////////////////////////////////////////////////////////
  // flag and control byte
  typedef struct packed {
    logic wdog;
    logic alarm;
    logic pfail;
    logic oscillator_fail_flag;
    logic cal;
    logic hold;
    logic snap;
  } rtcf_flags_t;

  rtcf_flags_t fl_q;
  rtcf_flags_t fl_d;
  logic [DATA_W-1:0] flag_byte;
  logic flags_wr;
  logic clk_wr;
  logic rd_clear;
  logic kept_loaded_q;
  logic kept_loaded_d;
  logic osc_fail_event;

  always_comb begin
    flag_byte = FLAGS_RESET;
    flag_byte[BIT_WDOG] = fl_q.wdog;
    flag_byte[BIT_ALARM] = fl_q.alarm;
    flag_byte[BIT_PFAIL] = fl_q.pfail;
    flag_byte[BIT_OSCILLATOR_FAIL_FLAG] = fl_q.oscillator_fail_flag;
    flag_byte[BIT_CAL] = fl_q.cal;
    flag_byte[BIT_HOLD] = fl_q.hold;
    flag_byte[BIT_SNAP] = fl_q.snap;
    flags_wr = wr_end && (wr_addr_q == FLAGS_ADDR);
    clk_wr = wr_end && fl_q.hold && (wr_addr_q >= CLK_REG_FIRST) &&
             (wr_addr_q <= CLK_REG_LAST); // R9
    // cleared at the end of the read, after the byte was latched at its start; flags set in between are cleared unseen
    rd_clear = rd_end && rd_flags_q;
    kept_loaded_d = 1'b1;
    fl_d = fl_q;
    if (rd_clear) begin
      fl_d.wdog = 1'b0; // R11
      fl_d.alarm = 1'b0; // R1
      fl_d.pfail = 1'b0; // R2
    end
    if (flags_wr) begin
      fl_d.cal = wr_data_q[BIT_CAL];
      fl_d.hold = wr_data_q[BIT_HOLD];
      fl_d.snap = wr_data_q[BIT_SNAP];
      if (!wr_data_q[BIT_OSCILLATOR_FAIL_FLAG]) begin
        fl_d.oscillator_fail_flag = 1'b0; // R4
      end
    end
    // events are applied last, so a set beats a clear in the same cycle
    if (watchdog_zero_i) begin
      fl_d.wdog = 1'b1; // R11
    end
    if (alarm_match_i) begin
      fl_d.alarm = 1'b1; // R1
    end
    if (pfail_s) begin
      fl_d.pfail = 1'b1; // R2
    end
    if (!kept_loaded_q && osc_fail_kept_i) begin
      fl_d.oscillator_fail_flag = 1'b1; // R4
    end
    if (osc_fail_event) begin
      fl_d.oscillator_fail_flag = 1'b1; // R3
    end
  end

  //////////////////////////////////////////////////////////////////////
  // power-up oscillator check
  rtcf_osc_state_t osc_st_q;
  rtcf_osc_state_t osc_st_d;
  logic [$clog2(OSC_CYCLES+1)-1:0] osc_cnt_q;
  logic [$clog2(OSC_CYCLES+1)-1:0] osc_cnt_d;

  always_comb begin
    osc_st_d = osc_st_q;
    osc_cnt_d = osc_cnt_q;
    osc_fail_event = 1'b0;
    case (osc_st_q)
      OSC_START: begin
        osc_cnt_d = '0;
        osc_st_d = OSC_CHECK;
      end
      OSC_CHECK: begin
        if (osc_run_s) begin
          osc_st_d = OSC_RUN;
        end else if (osc_cnt_q == OSC_CYCLES[$bits(osc_cnt_q)-1:0] - 1'b1) begin
          osc_fail_event = 1'b1; // R3
          osc_st_d = OSC_RUN;
        end else begin
          osc_cnt_d = osc_cnt_q + 1'b1;
        end
      end
      OSC_RUN: begin
        osc_st_d = OSC_RUN;
      end
      default: begin
        osc_st_d = OSC_START;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // calibration square wave and interrupt pin
  // the divider free-runs; the wave phase is not tied to the bit write
  logic [$clog2(CAL_CYCLES+1)-1:0] cal_cnt_q;
  logic [$clog2(CAL_CYCLES+1)-1:0] cal_cnt_d;
  logic cal_wave_q;
  logic cal_wave_d;
  logic int_oe_d;

  always_comb begin
    cal_wave_d = cal_wave_q;
    if (cal_cnt_q == CAL_CYCLES[$bits(cal_cnt_q)-1:0] - 1'b1) begin
      cal_cnt_d = '0;
      cal_wave_d = !cal_wave_q; // R5
    end else begin
      cal_cnt_d = cal_cnt_q + 1'b1;
    end
    // open drain: the pin is pulled low while enabled
    int_oe_d = fl_q.cal ? !cal_wave_q : int_request_i; // R5
  end

  //////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
      rd_flags_q <= 1'b0;
      fl_q <= '0; // R6
      kept_loaded_q <= 1'b0;
      osc_st_q <= OSC_START;
      osc_cnt_q <= '0;
      cal_cnt_q <= '0;
      cal_wave_q <= 1'b0;
      int_oe_o <= 1'b0;
      int_o <= 1'b0;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      time_hold_o <= 1'b0;
      time_load_o <= 1'b0;
      snapshot_o <= 1'b0;
      clk_reg_wr_o <= 1'b0;
      clk_reg_addr_o <= '0;
      clk_reg_data_o <= '0;
      osc_fail_flag_o <= 1'b0;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      rd_flags_q <= rd_flags_d;
      fl_q <= fl_d;
      kept_loaded_q <= kept_loaded_d;
      osc_st_q <= osc_st_d;
      osc_cnt_q <= osc_cnt_d;
      cal_cnt_q <= cal_cnt_d;
      cal_wave_q <= cal_wave_d;
      int_oe_o <= int_oe_d;
      int_o <= 1'b0;
      if (rd_start && addr_s == FLAGS_ADDR) begin
        dq_o <= flag_byte;
        dq_oe_o <= 1'b1;
      end else if (rd_end) begin
        dq_oe_o <= 1'b0;
      end
      time_hold_o <= fl_d.hold; // R7
      time_load_o <= fl_q.hold && !fl_d.hold; // R8
      snapshot_o <= fl_d.snap; // R10
      clk_reg_wr_o <= clk_wr; // R9
      clk_reg_addr_o <= wr_addr_q;
      clk_reg_data_o <= wr_data_q;
      osc_fail_flag_o <= fl_d.oscillator_fail_flag; // R4
    end
  end
endmodule

/* File: hw/rtcf_pkg.sv */
// constants and register layout of the clock flag and control byte
//////////////////////////////////////////////////////////////////////
// Operation
// [R1] alarm match sets alarm flag; reading the flag byte clears it
// [R2] supply below threshold sets power-fail flag; reading the flag byte clears it
// [R3] oscillator not running within first 5 ms after power-up sets oscillator-fail flag
// [R4] oscillator-fail flag only cleared by host writing zero; kept across power cycles
// [R5] calibration bit one drives 512 Hz square wave on interrupt pin
// [R6] calibration bit resets to zero at power-up
// [R7] write-hold bit one freezes updates of visible time registers
// [R8] write-hold bit going to zero loads time registers into counters
// [R9] clock registers writable only while write-hold set; flag byte always writable
// [R10] read-snapshot bit presents static copy of time registers
// [R11] watchdog reaching zero unreloaded sets watchdog flag; reading flag byte clears it
// [R12] host clears read-snapshot bit after reading to refresh the copy
package rtcf_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] FLAGS_ADDR = 17'h1fff0;
  localparam logic [ADDR_W-1:0] CLK_REG_FIRST = 17'h1fff1;
  localparam logic [ADDR_W-1:0] CLK_REG_LAST = 17'h1ffff;
  localparam int BIT_WDOG = 7;
  localparam int BIT_ALARM = 6;
  localparam int BIT_PFAIL = 5;
  localparam int BIT_OSCILLATOR_FAIL_FLAG = 4;
  localparam int BIT_CAL = 2;
  localparam int BIT_HOLD = 1;
  localparam int BIT_SNAP = 0;
  localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
  localparam int CLK_HZ = 100_000_000;
  localparam int OSC_CHECK_MS = 5;
  localparam int OSC_CHECK_CYCLES = CLK_HZ / 1000 * OSC_CHECK_MS;
  localparam int CAL_HZ = 512;
  // half period rounded down
  localparam int CAL_HALF_CYCLES = CLK_HZ / (2 * CAL_HZ);
  typedef enum logic [1:0] {
    OSC_CHECK = 2'b00,
    OSC_RUN = 2'b01,
    OSC_START = 2'b10
  } rtcf_osc_state_t;
endpackage

/* File: hw/rtcf_sync.sv */
// two flip-flop synchroniser for pins entering the clock domain
`timescale 1ns/1ps
module rtcf_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule

/* File: tb/rtcf_flags_ctrl_asserts.sv */
// concurrent checks on the ports of the flag and control block
`timescale 1ns/1ps
module rtcf_flags_ctrl_asserts
  import rtcf_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [rtcf_pkg::ADDR_W-1:0] addr_i,
  input wire logic ce_n_i,
  input wire logic [rtcf_pkg::DATA_W-1:0] dq_o,
  input wire logic dq_oe_o,
  input wire logic int_o,
  input wire logic time_hold_o,
  input wire logic time_load_o,
  input wire logic snapshot_o,
  input wire logic clk_reg_wr_o,
  input wire logic [rtcf_pkg::ADDR_W-1:0] clk_reg_addr_o,
  input wire logic osc_fail_flag_o
);
  logic [3:0] idle_q;
  logic [3:0] idle_d;
  // saturating so a long quiet spell never wraps back to look like a write
  always_comb begin
    idle_d = idle_q;
    if (sys_rst_i) idle_d = 4'hf;
    else if (!ce_n_i) idle_d = 4'h0;
    else if (idle_q != 4'hf) idle_d = idle_q + 4'h1;
  end
  always_ff @(posedge clock_i) idle_q <= idle_d;
  //////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_load_on_fall: assert property (time_load_o |-> !time_hold_o && $past(time_hold_o))
    else $error("load pulse without hold falling");
  a_load_single: assert property (time_load_o |=> !time_load_o)
    else $error("load pulse longer than one cycle");
  a_wr_needs_hold: assert property (clk_reg_wr_o |-> time_hold_o)
    else $error("clock register write while hold clear");
  a_wr_in_range: assert property (clk_reg_wr_o |-> clk_reg_addr_o >= CLK_REG_FIRST
    && clk_reg_addr_o <= CLK_REG_LAST) else $error("clock write outside range");
  a_oscillator_fail_flag_host_clear: assert property ($fell(osc_fail_flag_o) |-> idle_q < 4'h8)
    else $error("oscillator flag cleared without a write");
  a_hold_by_write: assert property ($changed(time_hold_o) |-> idle_q < 4'h8)
    else $error("hold bit changed without a write");
  a_snap_by_write: assert property ($changed(snapshot_o) |-> idle_q < 4'h8)
    else $error("snapshot bit changed without a write");
  a_read_flags_only: assert property ($rose(dq_oe_o) |-> addr_i == FLAGS_ADDR
    && !ce_n_i && !dq_o[3]) else $error("data driven outside a flag read");
  a_int_open_drain: assert property (int_o == 1'b0)
    else $error("interrupt pin driven high");
endmodule

/* File: tb/rtcf_flags_ctrl_tb.sv */
// self-checking bench for the clock flag and control byte
`timescale 1ns/1ps
module rtcf_flags_ctrl_tb;
  import rtcf_pkg::*;
  localparam int OSC_N = 20;
  localparam int CAL_N = 4;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic pfail = 1'b0, osc_run = 1'b0, alarm = 1'b0, wdog = 1'b0, int_req = 1'b0;
  logic kept = 1'b0;
  logic [16:0] addr, caddr, waddr;
  logic [7:0] hdq, ddq, bus, cdata, wdata;
  logic ce_n, we_n, oe_n, doe, int_oe, hold, load, snap, cwr, oscillator_fail_flag, prev_oe;
  int err_count = 0, checked = 0, wr_n = 0, ld_n = 0, tg_n = 0;
  always #5 clock_i = ~clock_i;
  assign bus = doe ? ddq : hdq;
  always @(posedge clock_i) begin
    if (cwr === 1'b1) begin
      wr_n++;
      waddr = caddr;
      wdata = cdata;
    end
    if (load === 1'b1) ld_n++;
    if (int_oe !== prev_oe) tg_n++;
    prev_oe = int_oe;
  end
  rtcf_host_model host (.clock_i(clock_i), .bus_i(bus), .addr_o(addr), .dq_o(hdq),
    .ce_n_o(ce_n), .we_n_o(we_n), .oe_n_o(oe_n));
  rtcf_flags_ctrl #(.OSC_CYCLES(OSC_N), .CAL_CYCLES(CAL_N)) dut (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .addr_i(addr), .dq_i(bus), .dq_o(ddq), .dq_oe_o(doe),
    .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .power_fail_threshold_i(pfail),
    .osc_running_i(osc_run), .osc_fail_kept_i(kept), .alarm_match_i(alarm),
    .watchdog_zero_i(wdog), .int_request_i(int_req), .int_o(), .int_oe_o(int_oe),
    .time_hold_o(hold), .time_load_o(load), .snapshot_o(snap), .clk_reg_wr_o(cwr),
    .clk_reg_addr_o(caddr), .clk_reg_data_o(cdata), .osc_fail_flag_o(oscillator_fail_flag));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [16:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.xfer(1'b0, a, 8'h00, q);
    chk(17'(q), 17'(e));
  endtask
  task automatic end_of_test();
    $display("mismatches %0d of %0d comparisons", err_count, checked);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // whole run is well under 10 us; a hang is cut long after that
  initial begin
    #100us;
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (OSC_N + 10) @(posedge clock_i);
    rdc(FLAGS_ADDR, 8'h10);
    chk(17'(oscillator_fail_flag), 17'h1);
    @(posedge clock_i) osc_run <= 1'b1;
    wr(FLAGS_ADDR, 8'h00);
    wr(FLAGS_ADDR, 8'h10);
    rdc(FLAGS_ADDR, 8'h00);
    @(posedge clock_i) {alarm, wdog, pfail} <= 3'h7;
    @(posedge clock_i) {alarm, wdog} <= 2'h0;
    repeat (3) @(posedge clock_i) pfail <= 1'b0;
    rdc(FLAGS_ADDR, 8'he0);
    rdc(FLAGS_ADDR, 8'h00);
    wr(17'h1fff5, 8'h33);
    chk(17'(wr_n), 17'h0);
    wr(FLAGS_ADDR, 8'h02);
    chk(17'(hold), 17'h1);
    wr(CLK_REG_LAST, 8'h5a);
    chk(17'(wr_n), 17'h1);
    chk(waddr, CLK_REG_LAST);
    chk(17'(wdata), 17'h5a);
    wr(FLAGS_ADDR, 8'h00);
    chk(17'(ld_n), 17'h1);
    chk(17'(hold), 17'h0);
    wr(FLAGS_ADDR, 8'h01);
    chk(17'(snap), 17'h1);
    wr(FLAGS_ADDR, 8'h00);
    chk(17'(snap), 17'h0);
    wr(FLAGS_ADDR, 8'h04);
    tg_n = 0;
    repeat (8 * CAL_N) @(posedge clock_i);
    #1 chk(17'(tg_n), 17'h8);
    wr(FLAGS_ADDR, 8'h00);
    @(posedge clock_i) int_req <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1 chk(17'(int_oe), 17'h1);
    // power cycle with the backed-up oscillator flag set and the oscillator running
    @(posedge clock_i) begin
      sys_rst_i <= 1'b1;
      kept <= 1'b1;
    end
    repeat (3) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (OSC_N + 10) @(posedge clock_i);
    #1 chk(17'(oscillator_fail_flag), 17'h1);
    rdc(FLAGS_ADDR, 8'h10);
    wr(FLAGS_ADDR, 8'h00);
    chk(17'(oscillator_fail_flag), 17'h0);
    end_of_test();
  end
endmodule
bind rtcf_flags_ctrl rtcf_flags_ctrl_asserts u_chk (.clock_i(clock_i),
  .sys_rst_i(sys_rst_i), .addr_i(addr_i), .ce_n_i(ce_n_i), .dq_o(dq_o),
  .dq_oe_o(dq_oe_o), .int_o(int_o), .time_hold_o(time_hold_o),
  .time_load_o(time_load_o), .snapshot_o(snapshot_o), .clk_reg_wr_o(clk_reg_wr_o),
  .clk_reg_addr_o(clk_reg_addr_o), .osc_fail_flag_o(osc_fail_flag_o));

/* File: tb/rtcf_host_model.sv */
// host processor model on the asynchronous sram-style pins of the flag block
`timescale 1ns/1ps
module rtcf_host_model
  import rtcf_pkg::*;
(
  input wire logic clock_i,
  input wire logic [rtcf_pkg::DATA_W-1:0] bus_i,
  output logic [rtcf_pkg::ADDR_W-1:0] addr_o,
  output logic [rtcf_pkg::DATA_W-1:0] dq_o,
  output logic ce_n_o,
  output logic we_n_o,
  output logic oe_n_o
);
  logic drv_q = 1'b0;
  logic [7:0] wd_q = 8'h00;
  logic [7:0] pat_q = 8'h55;
  initial begin
    addr_o = '0;
    ce_n_o = 1'b1;
    we_n_o = 1'b1;
    oe_n_o = 1'b1;
  end
  // released data lines keep changing so a stale byte never passes as valid
  always @(posedge clock_i) pat_q <= ~pat_q;
  assign dq_o = drv_q ? wd_q : pat_q;
  // six cycles active and six idle, above the three-cycle minimum each way
  task automatic xfer(input logic wr, input logic [16:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clock_i);
    addr_o <= a;
    wd_q <= d;
    drv_q <= wr;
    ce_n_o <= 1'b0;
    we_n_o <= !wr;
    oe_n_o <= wr;
    repeat (5) @(posedge clock_i);
    q = bus_i;
    @(posedge clock_i);
    ce_n_o <= 1'b1;
    we_n_o <= 1'b1;
    oe_n_o <= 1'b1;
    drv_q <= 1'b0;
    repeat (6) @(posedge clock_i);
    #1;
  endtask
endmodule
